// >>> design/unb_uart_top.sv
// Nine-bit asynchronous serial port with a fixed bit rate from the core clock,
// an APB register slave, one interrupt line and the reset-time mode strap pin.
// Assumes the APB master, the serial lines and the strap pin are external;
// the receive line and strap pin are asynchronous and are synchronised here.
// Summary of operation
// - The port runs only when the upper mode-select bit is 1 and the lower one is 0.
// - The bit rate is clock over 64, or clock over 32 when the rate-doubling bit is set.
// - A frame is a 0 start bit, eight data bits, a ninth bit and a 1 stop bit.
// - A transmission loads the eight buffer bits into the shift register, sent LSB first.
// - The transmit ninth-bit control value is loaded as the tenth bit on the line, after the eight data bits.
// - The start bit goes out only at the next bit-rate tick after a buffer write.
// - The transmit-done flag sets when the stop bit starts on the transmit line.
// - Received data bits shift into the receive register LSB first.
// - An accepted frame fills the buffer and ninth bit and sets the receive-done flag.
// - A frame is accepted only if receive-done is 0 and the stop bit is 1, else dropped.
// - The strap pin is sampled only as reset falls; it is released while reset is high and driven after the catch.
// - A low strap enters serial download mode, a high strap normal mode.
// - Reception starts on a falling edge of the receive line with a valid start bit.
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module unb_uart_top
  import unb_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // APB slave.
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial lines.
  input wire logic rxLine,
  output logic txLine,
  // Strap pin, enable active low.
  input wire logic progStoreEnIn,
  output logic progStoreEnOut,
  output logic progStoreEnOeN,
  // Mode and interrupt.
  output logic downloadMode,
  output logic irq
);

  unb_apb_req_s req;
  unb_ctrl_s ctrl_q;
  logic [1:0] mask_q;
  logic txDoneFlag_q, rxDoneFlag_q, rxNinthBit_q;
  logic [7:0] txBuf_q, rxBuf_q;
  logic txPend_q, txBusy_q;
  logic [10:0] txShift_q;
  logic [3:0] txBit_q;
  logic [5:0] baudCnt_q, bitLast;
  logic baudTick, modeOk;
  logic rxMeta_q, rxSync_q, rxPrev_q;
  unb_rx_e rxState_q;
  logic [5:0] rxCnt_q;
  logic [3:0] rxBit_q;
  logic [9:0] rxShift_q;
  logic rxFinal, rxAccept, txDoneEv;
  logic pinMeta_q, pinSync_q, resetDly_q, downloadMode_q, pinOeN_q;
  logic wrEn, rdEn, mapped;
  logic [31:0] rdData_d, prdata_q;

  assign req = '{paddr: paddr, psel: psel, penable: penable, pwrite: pwrite, pwdata: pwdata};

  // The slave never stalls, so every access phase completes in its first cycle.
  assign pready = 1'b1;
  assign mapped = (req.paddr[31:8] == 24'h000000) && (req.paddr[1:0] == 2'h0) &&
                  (req.paddr[7:0] <= OFF_DATA);
  assign pslverr = req.psel && req.penable && !mapped;
  assign wrEn = req.psel && req.penable && req.pwrite && mapped;
  assign rdEn = req.psel && !req.penable && !req.pwrite;

  assign modeOk = {ctrl_q.modeSelHi, ctrl_q.modeSelLo} == MODE_NINE_FIXED;
  assign bitLast = ctrl_q.rateDouble ? DIV_FAST_LAST : DIV_SLOW_LAST;
  assign baudTick = modeOk && (baudCnt_q == bitLast);

  always_ff @(posedge clock) begin
    if (reset || !modeOk || baudTick) begin
      baudCnt_q <= 6'h00;
    end else begin
      baudCnt_q <= baudCnt_q + 6'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_q <= unb_ctrl_s'(CTRL_RESET[4:0]);
      mask_q <= MASK_RESET;
    end else if (wrEn && req.paddr[7:0] == OFF_CTRL) begin
      ctrl_q <= unb_ctrl_s'(req.pwdata[4:0]);
    end else if (wrEn && req.paddr[7:0] == OFF_MASK) begin
      mask_q <= req.pwdata[1:0];
    end
  end

  // Read data is registered in the setup cycle, so it is stable for the access phase.
  always_comb begin
    rdData_d = 32'h00000000;
    case (req.paddr[7:0])
      OFF_CTRL: rdData_d[4:0] = ctrl_q;
      OFF_STAT: begin
        rdData_d[ST_TX_DONE] = txDoneFlag_q;
        rdData_d[ST_RX_DONE] = rxDoneFlag_q;
        rdData_d[ST_RX_NINTH] = rxNinthBit_q;
        rdData_d[ST_DOWNLOAD] = downloadMode_q;
        rdData_d[ST_TX_BUSY] = txBusy_q || txPend_q;
      end
      OFF_MASK: rdData_d[1:0] = mask_q;
      OFF_DATA: rdData_d[7:0] = rxBuf_q;
      default: rdData_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      prdata_q <= 32'h00000000;
    end else if (rdEn) begin
      prdata_q <= mapped ? rdData_d : 32'h00000000;
    end
  end
  assign prdata = prdata_q;

  // A buffer write only arms the transmitter; the frame waits for a tick.
  always_ff @(posedge clock) begin
    if (reset) begin
      txBuf_q <= 8'h00;
      txPend_q <= 1'b0;
    end else if (wrEn && req.paddr[7:0] == OFF_DATA && modeOk) begin
      txBuf_q <= req.pwdata[7:0];
      txPend_q <= 1'b1;
    end else if (baudTick && !txBusy_q) begin
      txPend_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset || !modeOk) begin
      txShift_q <= TX_IDLE_SHIFT;
      txBusy_q <= 1'b0;
      txBit_q <= 4'h0;
    end else if (baudTick && !txBusy_q && txPend_q) begin
      txShift_q <= {1'b1, ctrl_q.txNinthBit, txBuf_q, 1'b0};
      txBusy_q <= 1'b1;
      txBit_q <= 4'h0;
    end else if (baudTick && txBusy_q) begin
      txShift_q <= {1'b1, txShift_q[10:1]};
      if (txBit_q == FRAME_LAST) begin
        txBusy_q <= 1'b0;
      end
      txBit_q <= txBit_q + 4'h1;
    end
  end
  assign txLine = txShift_q[0];

  assign txDoneEv = baudTick && txBusy_q && (txBit_q == TX_STOP_NEXT);

  // Receive line synchroniser; the second stage and its delayed copy feed logic, never the first stage.
  always_ff @(posedge clock) begin
    if (reset) begin
      rxMeta_q <= 1'b1;
      rxSync_q <= 1'b1;
      rxPrev_q <= 1'b1;
    end else begin
      rxMeta_q <= rxLine;
      rxSync_q <= rxMeta_q;
      rxPrev_q <= rxSync_q;
    end
  end

  always_ff @(posedge clock) begin
    if (reset || !modeOk) begin
      rxState_q <= RX_IDLE;
      rxCnt_q <= 6'h00;
      rxBit_q <= 4'h0;
      rxShift_q <= 10'h000;
    end else begin
      case (rxState_q)
        RX_IDLE: begin
          rxCnt_q <= 6'h00;
          if (rxPrev_q && !rxSync_q) begin
            rxState_q <= RX_START;
          end
        end
        RX_START: begin
          rxCnt_q <= rxCnt_q + 6'h01;
          if (rxCnt_q == {1'b0, bitLast[5:1]}) begin
            rxCnt_q <= 6'h00;
            rxBit_q <= 4'h0;
            rxState_q <= rxSync_q ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          rxCnt_q <= rxCnt_q + 6'h01;
          if (rxCnt_q == bitLast) begin
            rxCnt_q <= 6'h00;
            rxShift_q <= {rxSync_q, rxShift_q[9:1]};
            rxBit_q <= rxBit_q + 4'h1;
            if (rxBit_q == RX_LAST_SAMPLE) begin
              rxState_q <= RX_IDLE;
            end
          end
        end
        default: rxState_q <= RX_IDLE;
      endcase
    end
  end

  // The stop bit is the live sample; the shift register holds data and ninth bit.
  assign rxFinal = modeOk && rxState_q == RX_DATA && rxCnt_q == bitLast &&
                   rxBit_q == RX_LAST_SAMPLE;
  assign rxAccept = rxFinal && !rxDoneFlag_q && rxSync_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      rxBuf_q <= 8'h00;
      rxNinthBit_q <= 1'b0;
    end else if (rxAccept) begin
      rxBuf_q <= rxShift_q[8:1];
      rxNinthBit_q <= rxShift_q[9];
    end
  end

  // Flags are sticky and cleared by writing one; a same-cycle event wins.
  always_ff @(posedge clock) begin
    if (reset) begin
      txDoneFlag_q <= 1'b0;
      rxDoneFlag_q <= 1'b0;
    end else begin
      if (txDoneEv) begin
        txDoneFlag_q <= 1'b1;
      end else if (wrEn && req.paddr[7:0] == OFF_STAT && req.pwdata[ST_TX_DONE]) begin
        txDoneFlag_q <= 1'b0;
      end
      if (rxAccept) begin
        rxDoneFlag_q <= 1'b1;
      end else if (wrEn && req.paddr[7:0] == OFF_STAT && req.pwdata[ST_RX_DONE]) begin
        rxDoneFlag_q <= 1'b0;
      end
    end
  end

  assign irq = |({rxDoneFlag_q, txDoneFlag_q} & mask_q);

  // Strap pin: released while reset is high, caught as reset falls, then driven.
  // The synchroniser keeps running through reset so it carries the released pin level.
  always_ff @(posedge clock) begin
    pinMeta_q <= progStoreEnIn;
    pinSync_q <= pinMeta_q;
  end

  always_ff @(posedge clock) begin
    resetDly_q <= reset;
  end

  // The catch waits one cycle after reset falls so the second stage shows the level
  // from the last reset cycle; the pin stays released until that cycle.
  logic catchPending_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      catchPending_q <= 1'b1;
      pinOeN_q <= 1'b1;
      downloadMode_q <= 1'b0;
    end else if (catchPending_q && !resetDly_q) begin
      catchPending_q <= 1'b0;
      pinOeN_q <= 1'b0;
      downloadMode_q <= !pinSync_q;
    end
  end

  assign progStoreEnOeN = pinOeN_q;
  assign progStoreEnOut = 1'b1;
  assign downloadMode = downloadMode_q;

  property p_mode_gate;
    @(posedge clock) disable iff (reset)
      !modeOk |=> (rxState_q == RX_IDLE) && !txBusy_q;
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("port active outside its mode");

  property p_rate;
    @(posedge clock) disable iff (reset)
      baudTick && $stable(ctrl_q) |=> !baudTick [*8];
  endproperty
  a_rate: assert property (p_rate) else $error("bit ticks too close together");

  property p_start_bit;
    @(posedge clock) disable iff (reset)
      $rose(txBusy_q) |-> !txLine && txShift_q[10] && txShift_q[9] == $past(ctrl_q.txNinthBit);
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("bad frame load");

  property p_tx_data;
    @(posedge clock) disable iff (reset)
      $rose(txBusy_q) |-> txShift_q[8:1] == $past(txBuf_q);
  endproperty
  a_tx_data: assert property (p_tx_data) else $error("data not loaded");

  property p_tx_wait;
    @(posedge clock) disable iff (reset)
      $rose(txBusy_q) |-> $past(baudTick) && $past(txPend_q);
  endproperty
  a_tx_wait: assert property (p_tx_wait) else $error("start bit before tick");

  property p_tx_done;
    @(posedge clock) disable iff (reset)
      txDoneEv |=> txLine && txDoneFlag_q && txBit_q == FRAME_LAST;
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("done flag not with stop bit");

  property p_rx_accept;
    @(posedge clock) disable iff (reset)
      rxAccept |=> rxDoneFlag_q && rxBuf_q == $past(rxShift_q[8:1]) &&
                   rxNinthBit_q == $past(rxShift_q[9]);
  endproperty
  a_rx_accept: assert property (p_rx_accept) else $error("accepted frame not stored");

  property p_rx_drop;
    @(posedge clock) disable iff (reset)
      rxFinal && (rxDoneFlag_q || !rxSync_q) |=> $stable(rxBuf_q) && $stable(rxNinthBit_q);
  endproperty
  a_rx_drop: assert property (p_rx_drop) else $error("bad frame overwrote buffer");

  property p_glitch;
    @(posedge clock) disable iff (reset)
      rxState_q == RX_START && rxSync_q |=> rxState_q != RX_DATA;
  endproperty
  a_glitch: assert property (p_glitch) else $error("false start accepted");

  property p_strap;
    @(posedge clock) disable iff (reset)
      !catchPending_q && !$past(catchPending_q) |-> !progStoreEnOeN && $stable(downloadMode);
  endproperty
  a_strap: assert property (p_strap) else $error("strap pin not driven after catch");

endmodule
`default_nettype wire

// >>> design/unb_pkg.sv
// Package for the nine-bit fixed-rate serial port: register map, field layouts,
// divider values and frame geometry.
// Assumes a single 125 MHz clock and an APB master with 32-bit data.
package unb_pkg;

  localparam int CLK_HZ = 125000000;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0c;

  // Status and mask bit positions.
  localparam int ST_TX_DONE = 0;
  localparam int ST_RX_DONE = 1;
  localparam int ST_RX_NINTH = 2;
  localparam int ST_DOWNLOAD = 3;
  localparam int ST_TX_BUSY = 4;

  // Mode-select code of the nine-bit fixed-rate mode.
  localparam logic [1:0] MODE_NINE_FIXED = 2'h2;

  // Last divider count of each bit: slow rate and doubled rate.
  localparam logic [5:0] DIV_SLOW_LAST = 6'h3f;
  localparam logic [5:0] DIV_FAST_LAST = 6'h1f;

  // Frame geometry: start, eight data, ninth, stop.
  localparam logic [3:0] FRAME_LAST = 4'ha;
  localparam logic [3:0] TX_STOP_NEXT = 4'h9;
  localparam logic [3:0] RX_LAST_SAMPLE = 4'h9;

  // Values after reset.
  localparam logic [10:0] TX_IDLE_SHIFT = 11'h7ff;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] MASK_RESET = 2'h0;

  typedef struct packed {
    logic txNinthBit;
    logic rateDouble;
    logic multiprocEnable;
    logic modeSelLo;
    logic modeSelHi;
  } unb_ctrl_s;

  typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } unb_apb_req_s;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} unb_rx_e;

endpackage

// >>> sim/unb_serial_peer.sv
// Far-end serial device model: sends frames to the port and captures frames from it.
// Assumes the bench passes the bit period in core clocks with each send and capture call.
`timescale 1ns/1ps
`default_nettype none
module unb_serial_peer (
  // Clock.
  input wire logic clock,
  // Serial lines seen from the peer.
  output var logic toPort,
  input wire logic fromPort
);
  initial toPort = 1'b1;
  // Start 0, data LSB first, ninth, stop, then one idle period.
  task automatic send(input logic [7:0] d, input logic n, input logic s, input int p);
    logic [10:0] f;
    f = {s, n, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      toPort <= f[i];
      repeat (p) @(posedge clock);
    end
    toPort <= 1'b1;
    repeat (p) @(posedge clock);
  endtask
  // A low pulse too short to be a start bit.
  task automatic glitch(input int c);
    toPort <= 1'b0;
    repeat (c) @(posedge clock);
    toPort <= 1'b1;
  endtask
  // Samples mid-bit so a wrong bit rate shows up as wrong bits.
  task automatic capture(input int p, output logic [10:0] f);
    int w;
    w = 0;
    while (fromPort !== 1'b0 && w < 3000) begin
      @(posedge clock);
      w++;
    end
    repeat (p / 2) @(posedge clock);
    for (int i = 0; i < 11; i++) begin
      f[i] = fromPort;
      if (i < 10) repeat (p) @(posedge clock);
    end
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_uart_nine_bit_fixed_baud.sv
// Self-checking bench for the nine-bit serial port through its APB registers.
// Assumes a strap jumper that pulls the pin low, else a pull-up.
`timescale 1ns/1ps
`default_nettype none
module tb_uart_nine_bit_fixed_baud;
  import unb_pkg::*;
  localparam int LIMIT = 30000;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [31:0] paddr = 32'h0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rxLine, txLine, pinOut, pinOeN, downloadMode, irq;
  logic jumper = 1'b1;
  wire logic strapPin;
  int cycles = 0;
  int mismatches = 0;
  int testsRun = 0;
  logic [31:0] rd;
  logic err;
  logic [10:0] frame;
  logic [31:0] offModes [3] = '{32'h0, 32'h2, 32'h3};

  assign strapPin = !pinOeN ? pinOut : !jumper;

  unb_uart_top dut_u (.clock(clock), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxLine(rxLine), .txLine(txLine),
    .progStoreEnIn(strapPin), .progStoreEnOut(pinOut), .progStoreEnOeN(pinOeN),
    .downloadMode(downloadMode), .irq(irq));
  unb_serial_peer peer (.clock(clock), .toPort(rxLine), .fromPort(txLine));

  always #4 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] x,
                       input string n);
    apb(1'b0, a, 32'h0, rd, err);
    check(n, rd & m, x);
  endtask
  task automatic do_reset(input logic j);
    @(posedge clock);
    jumper <= j;
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    check("pin released", pinOeN, 1);
    @(posedge clock);
    reset <= 1'b0;
    repeat (4) @(posedge clock);
    check("pin driven", pinOeN, 0);
    check("pin level", pinOut, 1);
    check("download", downloadMode, j);
  endtask

  initial begin
    do_reset(1'b1);
    rdchk(OFF_STAT, 32'h8, 32'h8, "stat dl");
    do_reset(1'b0);
    rdchk(OFF_CTRL, 32'hffffffff, 32'h0, "ctrl rst");
    foreach (offModes[i]) begin
      wr(OFF_CTRL, offModes[i]);
      wr(OFF_DATA, 32'h55);
      repeat (800) @(posedge clock);
      rdchk(OFF_STAT, 32'h13, 32'h0, "mode off");
    end
    $display("test strap and mode done");
    wr(OFF_MASK, 32'h1);
    for (int k = 0; k < 2; k++) begin
      wr(OFF_CTRL, {27'h0, ~k[0], k[0], 3'h1});
      wr(OFF_DATA, k ? 32'h3c : 32'ha5);
      peer.capture(k ? 32 : 64, frame);
      check("tx frame", frame, {1'b1, ~k[0], k ? 8'h3c : 8'ha5, 1'b0});
      check("tx irq", irq, 1);
      rdchk(OFF_STAT, 32'h1, 32'h1, "tx done");
      wr(OFF_STAT, 32'h1);
      @(posedge clock);
      check("irq clear", irq, 0);
      repeat (64) @(posedge clock);
    end
    $display("test transmit done");
    wr(OFF_CTRL, 32'h1);
    wr(OFF_MASK, 32'h2);
    peer.send(8'h96, 1'b1, 1'b1, 64);
    check("rx irq", irq, 1);
    rdchk(OFF_STAT, 32'h6, 32'h6, "rx flags");
    rdchk(OFF_DATA, 32'hff, 32'h96, "rx data");
    peer.send(8'h11, 1'b0, 1'b1, 64);
    rdchk(OFF_DATA, 32'hff, 32'h96, "rx full");
    rdchk(OFF_STAT, 32'h4, 32'h4, "ninth kept");
    wr(OFF_STAT, 32'h2);
    peer.send(8'h22, 1'b0, 1'b0, 64);
    rdchk(OFF_STAT, 32'h2, 32'h0, "bad stop");
    peer.glitch(8);
    repeat (800) @(posedge clock);
    rdchk(OFF_STAT, 32'h2, 32'h0, "glitch");
    peer.send(8'h5a, 1'b0, 1'b1, 64);
    rdchk(OFF_STAT, 32'h6, 32'h2, "rx again");
    rdchk(OFF_DATA, 32'hff, 32'h5a, "rx data2");
    apb(1'b0, 32'h10, 32'h0, rd, err);
    check("unmapped", err, 1);
    $display("test receive done");
    finish_test();
  end
endmodule
`default_nettype wire
